// file: core/port_cfg_pkg.sv
// Constants, register map and carrier types of the port configuration block.
package port_cfg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PIN_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W = 7;
  localparam int unsigned REMAP_N = 128;

  // ----------------------------------------------------------------
  // Register word offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_DIRECTION = 4'h0;
  localparam logic [3:0] OFF_OUT_LATCH = 4'h1;
  localparam logic [3:0] OFF_PIN_STATE = 4'h2;
  localparam logic [3:0] OFF_OPEN_DRAIN = 4'h3;
  localparam logic [3:0] OFF_ANALOG_SEL = 4'h4;
  localparam logic [3:0] OFF_CHG_ENABLE = 4'h5;
  localparam logic [3:0] OFF_PULL_UP = 4'h6;
  localparam logic [3:0] OFF_PULL_DOWN = 4'h7;
  localparam logic [3:0] OFF_CHG_STATUS = 4'h8;
  localparam logic [3:0] OFF_CHG_MASK = 4'h9;
  localparam logic [3:0] OFF_UART1_RX_SEL = 4'ha;
  localparam logic [3:0] OFF_UART2_RX_SEL = 4'hb;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_DIRECTION = 16'hffff;
  localparam logic [15:0] RST_ANALOG_SEL = 16'hffff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [6:0] RST_RX_SEL = 7'h00;
  localparam int unsigned RX_SEL_LSB = 0;
  localparam int unsigned RX_SEL_MSB = 6;
  localparam logic [6:0] RX_SEL_TIED_LOW = 7'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] pull_up;
    logic [15:0] pull_down;
    logic [15:0] analog_lvl;
    logic [15:0] analog_en;
  } pin_drive_t;

endpackage

// file: core/port_pin_config_change_notify.sv
// One 16-pin general-purpose port with change notification and UART receive remapping.
`timescale 1ns/100ps

module port_pin_config_change_notify (
  input wire logic i_mclk, // System clock, 20 MHz.
  input wire logic i_rst, // Synchronous reset, active high.
  input wire port_cfg_pkg::bus_req_t i_bus, // Register request.
  output logic [15:0] o_rdata_ff, // Read data, one cycle after the read strobe.
  input wire logic [15:0] i_pin_in, // Pad input levels.
  input wire logic [127:0] i_remap_in, // Remappable input pins by number.
  input wire logic i_sleep, // Core is asleep.
  output port_cfg_pkg::pin_drive_t o_pin_ff, // Pad drive and analog hand-over.
  output logic o_uart1_rx_ff, // Routed UART1 receive input.
  output logic o_uart2_rx_ff, // Routed UART2 receive input.
  output logic o_irq_ff // Change interrupt, level.
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic remap_pick(input logic [127:0] vec, input logic [6:0] code);
    logic bit_v;
    bit_v = 1'b0;
    if (code != port_cfg_pkg::RX_SEL_TIED_LOW) begin
      bit_v = vec[code];
    end
    return bit_v;
  endfunction

  function automatic logic [15:0] w1c(input logic [15:0] cur, input logic [15:0] clr,
                                      input logic [15:0] set);
    return (cur & ~clr) | set;
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] direction_ff;
  logic [15:0] out_latch_ff;
  logic [15:0] open_drain_ff;
  logic [15:0] analog_sel_ff;
  logic [15:0] chg_enable_ff;
  logic [15:0] pull_up_ff;
  logic [15:0] pull_down_ff;
  logic [15:0] chg_status_ff;
  logic [15:0] chg_mask_ff;
  logic [6:0] uart1_sel_ff;
  logic [6:0] uart2_sel_ff;

  logic wr_dir;
  logic wr_lat;
  logic wr_od;
  logic wr_an;
  logic wr_cen;
  logic wr_pu;
  logic wr_pd;
  logic wr_sts;
  logic wr_msk;
  logic wr_u1;
  logic wr_u2;

  assign wr_dir = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_DIRECTION);
  assign wr_lat = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_OUT_LATCH);
  assign wr_od = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_OPEN_DRAIN);
  assign wr_an = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_ANALOG_SEL);
  assign wr_cen = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_CHG_ENABLE);
  assign wr_pu = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_PULL_UP);
  assign wr_pd = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_PULL_DOWN);
  assign wr_sts = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_CHG_STATUS);
  assign wr_msk = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_CHG_MASK);
  assign wr_u1 = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_UART1_RX_SEL);
  assign wr_u2 = i_bus.wr && (i_bus.addr == port_cfg_pkg::OFF_UART2_RX_SEL);

  // ----------------------------------------------------------------
  // Direction and output latch
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      direction_ff <= port_cfg_pkg::RST_DIRECTION;
    end else if (wr_dir) begin
      direction_ff <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      out_latch_ff <= port_cfg_pkg::RST_ZERO;
    end else if (wr_lat) begin
      out_latch_ff <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      open_drain_ff <= port_cfg_pkg::RST_ZERO;
    end else if (wr_od) begin
      open_drain_ff <= i_bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Analog selection
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      analog_sel_ff <= port_cfg_pkg::RST_ANALOG_SEL;
    end else if (wr_an) begin
      analog_sel_ff <= i_bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Weak pulls and change enables
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pull_up_ff <= port_cfg_pkg::RST_ZERO;
    end else if (wr_pu) begin
      pull_up_ff <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pull_down_ff <= port_cfg_pkg::RST_ZERO;
    end else if (wr_pd) begin
      pull_down_ff <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      chg_enable_ff <= port_cfg_pkg::RST_ZERO;
    end else if (wr_cen) begin
      chg_enable_ff <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      chg_mask_ff <= port_cfg_pkg::RST_ZERO;
    end else if (wr_msk) begin
      chg_mask_ff <= i_bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // UART receive input selection
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      uart1_sel_ff <= port_cfg_pkg::RST_RX_SEL;
    end else if (wr_u1) begin
      uart1_sel_ff <= i_bus.wdata[port_cfg_pkg::RX_SEL_MSB:port_cfg_pkg::RX_SEL_LSB];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      uart2_sel_ff <= port_cfg_pkg::RST_RX_SEL;
    end else if (wr_u2) begin
      uart2_sel_ff <= i_bus.wdata[port_cfg_pkg::RX_SEL_MSB:port_cfg_pkg::RX_SEL_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Three stages; a level is taken only once stages two and three agree,
  // which rejects a single-cycle glitch at the cost of one more cycle.
  logic [15:0] pin_s1_ff;
  logic [15:0] pin_s2_ff;
  logic [15:0] pin_s3_ff;
  logic [15:0] pin_q_ff;
  logic [127:0] rmp_s1_ff;
  logic [127:0] rmp_s2_ff;
  logic [127:0] rmp_s3_ff;
  logic [127:0] rmp_q_ff;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pin_s1_ff <= port_cfg_pkg::RST_ZERO;
      pin_s2_ff <= port_cfg_pkg::RST_ZERO;
      pin_s3_ff <= port_cfg_pkg::RST_ZERO;
      pin_q_ff <= port_cfg_pkg::RST_ZERO;
    end else begin
      pin_s1_ff <= i_pin_in;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_q_ff <= (pin_s2_ff & pin_s3_ff) | (pin_q_ff & (pin_s2_ff ^ pin_s3_ff));
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rmp_s1_ff <= '0;
      rmp_s2_ff <= '0;
      rmp_s3_ff <= '0;
      rmp_q_ff <= '0;
    end else begin
      rmp_s1_ff <= i_remap_in;
      rmp_s2_ff <= rmp_s1_ff;
      rmp_s3_ff <= rmp_s2_ff;
      rmp_q_ff <= (rmp_s2_ff & rmp_s3_ff) | (rmp_q_ff & (rmp_s2_ff ^ rmp_s3_ff));
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_uart1_rx_ff <= 1'b0;
      o_uart2_rx_ff <= 1'b0;
    end else begin
      o_uart1_rx_ff <= remap_pick(rmp_q_ff, uart1_sel_ff);
      o_uart2_rx_ff <= remap_pick(rmp_q_ff, uart2_sel_ff);
    end
  end

  // ----------------------------------------------------------------
  // Change notification
  // ----------------------------------------------------------------
  // The reference level is frozen during sleep, so a pin that moved while
  // the core slept still differs from it once the clock returns. A pulse
  // that starts and ends inside one clock-stopped interval is not seen.
  logic [15:0] ref_level_ff;
  logic [15:0] chg_hit;

  assign chg_hit = (pin_q_ff ^ ref_level_ff) & chg_enable_ff & direction_ff;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ref_level_ff <= port_cfg_pkg::RST_ZERO;
    end else if (!i_sleep) begin
      ref_level_ff <= pin_q_ff;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      chg_status_ff <= port_cfg_pkg::RST_ZERO;
    end else if (wr_sts) begin
      chg_status_ff <= w1c(chg_status_ff, i_bus.wdata, chg_hit);
    end else begin
      chg_status_ff <= chg_status_ff | chg_hit;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_irq_ff <= 1'b0;
    end else begin
      o_irq_ff <= |(chg_status_ff & chg_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pin_ff <= '0;
    end else begin
      o_pin_ff.out <= out_latch_ff & ~open_drain_ff;
      o_pin_ff.oe <= ~direction_ff & ~(open_drain_ff & out_latch_ff);
      o_pin_ff.pull_up <= pull_up_ff;
      o_pin_ff.pull_down <= pull_down_ff;
      o_pin_ff.analog_lvl <= out_latch_ff & ~direction_ff & analog_sel_ff;
      o_pin_ff.analog_en <= ~direction_ff & analog_sel_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        port_cfg_pkg::OFF_DIRECTION: nxt_rdata = direction_ff;
        port_cfg_pkg::OFF_OUT_LATCH: nxt_rdata = out_latch_ff;
        port_cfg_pkg::OFF_PIN_STATE: nxt_rdata = pin_q_ff & ~(analog_sel_ff & direction_ff);
        port_cfg_pkg::OFF_OPEN_DRAIN: nxt_rdata = open_drain_ff;
        port_cfg_pkg::OFF_ANALOG_SEL: nxt_rdata = analog_sel_ff;
        port_cfg_pkg::OFF_CHG_ENABLE: nxt_rdata = chg_enable_ff;
        port_cfg_pkg::OFF_PULL_UP: nxt_rdata = pull_up_ff;
        port_cfg_pkg::OFF_PULL_DOWN: nxt_rdata = pull_down_ff;
        port_cfg_pkg::OFF_CHG_STATUS: nxt_rdata = chg_status_ff;
        port_cfg_pkg::OFF_CHG_MASK: nxt_rdata = chg_mask_ff;
        port_cfg_pkg::OFF_UART1_RX_SEL: nxt_rdata = {9'h000, uart1_sel_ff};
        port_cfg_pkg::OFF_UART2_RX_SEL: nxt_rdata = {9'h000, uart2_sel_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata_ff <= '0;
    end else begin
      o_rdata_ff <= nxt_rdata;
    end
  end

endmodule

// file: dv/port_cfg_props.sv
// Concurrent checks on the ports of the port configuration block.
`timescale 1ns/100ps
module port_cfg_props (
  input wire logic i_mclk, // Clock.
  input wire logic i_rst, // Reset.
  input wire port_cfg_pkg::bus_req_t i_bus, // Register request.
  input wire logic [15:0] o_rdata_ff, // Read data.
  input wire logic [15:0] i_pin_in, // Pad levels.
  input wire logic i_sleep, // Sleep level.
  input wire port_cfg_pkg::pin_drive_t o_pin_ff, // Pad drive.
  input wire logic o_uart1_rx_ff, // UART1 receive.
  input wire logic o_irq_ff // Interrupt.
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  logic [3:0] a;
  logic [15:0] pad_ff;
  logic [3:0] quiet_ff;
  assign a = i_bus.addr;
  // An interrupt may only rise shortly after a pad change or a mask write; sleep restarts the count.
  always_ff @(posedge i_mclk) begin
    pad_ff <= i_pin_in;
    if (i_rst || i_sleep || i_pin_in != pad_ff) quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hf) quiet_ff <= quiet_ff + 4'h1;
  end
  rdata_idle_a: assert property (
    !i_bus.rd |=> o_rdata_ff == 16'h0000) else $error("read data outside a read");
  sel_upper_a: assert property (
    i_bus.rd && (a == 4'ha || a == 4'hb) |=> o_rdata_ff[15:7] == 9'h000)
    else $error("select upper bits not zero");
  open_drain_a: assert property (
    i_bus.wr && a == 4'h3 |-> ##2 (o_pin_ff.out & $past(i_bus.wdata, 2)) == 16'h0000)
    else $error("open-drain pin driven high");
  pull_up_a: assert property (
    i_bus.wr && a == 4'h6 |-> ##2 o_pin_ff.pull_up == $past(i_bus.wdata, 2))
    else $error("pull-up enables wrong");
  pull_down_a: assert property (
    i_bus.wr && a == 4'h7 |-> ##2 o_pin_ff.pull_down == $past(i_bus.wdata, 2))
    else $error("pull-down enables wrong");
  rx_tie_a: assert property (
    i_bus.wr && a == 4'ha && i_bus.wdata[6:0] == 7'h00 |-> ##2 !o_uart1_rx_ff)
    else $error("tied receive input not low");
  irq_fall_a: assert property (
    $fell(o_irq_ff) |-> $past(i_bus.wr, 2) && ($past(a, 2) == 4'h8 || $past(a, 2) == 4'h9))
    else $error("interrupt dropped without a clear");
  irq_cause_a: assert property (
    $rose(o_irq_ff) |-> quiet_ff < 4'h9 || ($past(i_bus.wr, 2) && $past(a, 2) == 4'h9))
    else $error("interrupt without a pin change");
  irq_c: cover property ($rose(o_irq_ff));
  sel_c: cover property (i_bus.rd && a == 4'ha);
  od_c: cover property (i_bus.wr && a == 4'h3);
endmodule

// file: dv/port_pad_model.sv
// Pad model: resolves each pin from the block's drive, the far device and the weak pulls.
`timescale 1ns/100ps
module port_pad_model (
  input wire logic i_mclk, // Clock.
  input wire port_cfg_pkg::pin_drive_t i_drive, // Drive from the block.
  input wire logic [15:0] i_ext, // Level of the far device.
  input wire logic [15:0] i_ext_en, // Far device drives the pin.
  output logic [15:0] o_pad // Resolved pin level.
);
  // A floating pin toggles each cycle, so the block's input filter holds its stale level as if it were driven.
  logic [15:0] float_ff = 16'h0000;
  always_ff @(posedge i_mclk) float_ff <= ~float_ff;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (i_drive.oe[i]) o_pad[i] = i_drive.out[i];
      else if (i_ext_en[i]) o_pad[i] = i_ext[i];
      else if (i_drive.pull_up[i]) o_pad[i] = 1'b1;
      else if (i_drive.pull_down[i]) o_pad[i] = 1'b0;
      else o_pad[i] = float_ff[i];
    end
  end
endmodule

// file: dv/tb_port_pin_config_change_notify.sv
// Self-checking bench for the port configuration block.
`timescale 1ns/100ps
module tb_port_pin_config_change_notify;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  port_cfg_pkg::bus_req_t i_bus = '0;
  logic [15:0] o_rdata_ff;
  logic [15:0] i_pin_in;
  logic [127:0] i_remap_in = '0;
  logic i_sleep = 1'b0;
  port_cfg_pkg::pin_drive_t o_pin_ff;
  logic o_uart1_rx_ff;
  logic o_uart2_rx_ff;
  logic o_irq_ff;
  logic [15:0] ext = 16'h0000;
  logic [15:0] ext_en = 16'hffff;
  int err_count = 0;
  int checked = 0;
  initial begin
    forever #25 i_mclk = ~i_mclk;
  end
  port_pin_config_change_notify dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_bus(i_bus),
    .o_rdata_ff(o_rdata_ff), .i_pin_in(i_pin_in), .i_remap_in(i_remap_in),
    .i_sleep(i_sleep), .o_pin_ff(o_pin_ff), .o_uart1_rx_ff(o_uart1_rx_ff),
    .o_uart2_rx_ff(o_uart2_rx_ff), .o_irq_ff(o_irq_ff));
  port_pad_model pads (.i_mclk(i_mclk), .i_drive(o_pin_ff), .i_ext(ext),
    .i_ext_en(ext_en), .o_pad(i_pin_in));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_mclk);
    i_bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_mclk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_mclk);
    i_bus.rd <= 1'b0;
    #1;
    chk(o_rdata_ff, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (o_irq_ff !== exp && n < 20) begin
      settle(1);
      n++;
    end
    chk({15'h0000, o_irq_ff}, {15'h0000, exp});
    if (n == 20) final_report();
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), (a == 0 || a == 4) ? 16'hffff : 16'h0000);
    end
    $display("Reset values done");
    ext <= 16'ha5c3;
    wr(4'h4, 16'h00ff);
    settle(6);
    rd(4'h2, 16'ha500);
    wr(4'h4, 16'h0000);
    rd(4'h2, 16'ha5c3);
    $display("Pin state done");
    wr(4'h4, 16'h00ff);
    wr(4'h1, 16'h0f0f);
    wr(4'h3, 16'hff00);
    wr(4'h0, 16'h0000);
    settle(2);
    chk(o_pin_ff.out, 16'h000f);
    chk(o_pin_ff.oe, 16'hf0ff);
    chk(o_pin_ff.analog_en, 16'h00ff);
    chk(o_pin_ff.analog_lvl & 16'h00ff, 16'h000f);
    wr(4'h0, 16'hffff);
    wr(4'h3, 16'h0000);
    wr(4'h4, 16'h0000);
    wr(4'h6, 16'h1234);
    wr(4'h7, 16'h8001);
    settle(2);
    chk(o_pin_ff.pull_up, 16'h1234);
    chk(o_pin_ff.pull_down, 16'h8001);
    // The far device lets go of the pulled pins, so only the weak pulls set their level.
    ext_en <= 16'h6dca;
    settle(6);
    rd(4'h2, 16'h37f6);
    ext_en <= 16'hffff;
    settle(6);
    $display("Drive and pulls done");
    ext <= 16'h0000;
    wr(4'h5, 16'h0004);
    wr(4'h9, 16'h0004);
    settle(8);
    wr(4'h8, 16'hffff);
    ext <= 16'h0008;
    settle(10);
    rd(4'h8, 16'h0000);
    ext <= 16'h000c;
    wait_irq(1'b1);
    settle(10);
    rd(4'h8, 16'h0004);
    wr(4'h8, 16'h0004);
    wait_irq(1'b0);
    rd(4'h8, 16'h0000);
    wr(4'h9, 16'h0000);
    ext <= 16'h0008;
    settle(10);
    rd(4'h8, 16'h0004);
    chk({15'h0000, o_irq_ff}, 16'h0000);
    wr(4'h8, 16'hffff);
    i_sleep <= 1'b1;
    ext <= 16'h000c;
    settle(10);
    @(posedge i_mclk);
    i_sleep <= 1'b0;
    settle(10);
    rd(4'h8, 16'h0004);
    $display("Change notify done");
    wr(4'ha, 16'hffff);
    rd(4'ha, 16'h007f);
    wr(4'ha, 16'h0079);
    wr(4'hb, 16'h0005);
    i_remap_in[121] <= 1'b1;
    settle(8);
    chk({15'h0000, o_uart1_rx_ff}, 16'h0001);
    chk({15'h0000, o_uart2_rx_ff}, 16'h0000);
    @(posedge i_mclk);
    i_remap_in <= 128'h20;
    settle(8);
    chk({15'h0000, o_uart1_rx_ff}, 16'h0000);
    chk({15'h0000, o_uart2_rx_ff}, 16'h0001);
    wr(4'ha, 16'h0000);
    i_remap_in <= '1;
    settle(8);
    chk({15'h0000, o_uart1_rx_ff}, 16'h0000);
    rd(4'hb, 16'h0005);
    $display("Remap done");
    final_report();
  end
endmodule
bind port_pin_config_change_notify port_cfg_props props (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_bus(i_bus), .o_rdata_ff(o_rdata_ff), .i_pin_in(i_pin_in), .i_sleep(i_sleep),
  .o_pin_ff(o_pin_ff), .o_uart1_rx_ff(o_uart1_rx_ff), .o_irq_ff(o_irq_ff));
